// *** pkg/psr_defs.svh ***
// What this block does
// - Sample command bits on rising serial clock
// - Update data out on rising serial clock
// - Data out carries result, calibration or status
// - Five commands: pressure, temperature, two calib, reset
// - Three high bits before, three low after
// - Four-bit setup field selects the operation
// - Conversion acknowledged: out rises in last stop bit
// - Clock held low; out falls when conversion done
// - Seventeen clocks shift out the 16-bit result
// - Readout pauses with clock, resumes same bit
// - 21-bit reset pattern resyncs from any state
// - Pressure and temperature results are 16-bit unsigned
// - Four 16-bit calibration words, 64 bits total
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH

`define PSR_START_RUN 3'b111
`define PSR_STOP_RUN 3'b000
`define PSR_SETUP_W 4
`define PSR_CODE_PRESS 4'hA
`define PSR_CODE_TEMP 4'h9
`define PSR_CODE_CAL13 4'h5
`define PSR_CODE_CAL24 4'h6
`define PSR_RST_LEN 21
`define PSR_RST_PAT 21'h155540
`define PSR_ACK_CLKS 6'h02
`define PSR_READ_CLKS 6'h11
`define PSR_CAL_LEAD 6'h01
`define PSR_CAL_BITS 6'h20
`define PSR_RES_W 16
`define PSR_CONV_MS 35
`define PSR_MCLK_HZ 32768
`define PSR_CONV_MCLK ((`PSR_CONV_MS * `PSR_MCLK_HZ) / 1000)
`define PSR_CALIB_W1 16'h1111
`define PSR_CALIB_W2 16'h2222
`define PSR_CALIB_W3 16'h3333
`define PSR_CALIB_W4 16'h4444

`endif

// *** pkg/psr_pkg.sv ***
package psr_pkg;

  typedef enum logic [2:0]
  {
    PSR_IDLE = 3'b000,
    PSR_ACK = 3'b001,
    PSR_WAIT = 3'b010,
    PSR_READ = 3'b011,
    PSR_CAL = 3'b100
  } psr_state_t;

  typedef enum logic [2:0]
  {
    PSR_CMD_NONE = 3'b000,
    PSR_CMD_PRESS = 3'b001,
    PSR_CMD_TEMP = 3'b010,
    PSR_CMD_CAL13 = 3'b011,
    PSR_CMD_CAL24 = 3'b100
  } psr_cmd_t;

endpackage

// *** rtl/psr_conv.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psr_defs.svh"

module psr_conv
  import psr_pkg::*;
#(
  parameter int CONV_MCLK = `PSR_CONV_MCLK
)
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic mclk_i,
  input wire logic start_tg_i,
  input wire logic temp_sel_i,
  input wire logic taken_tg_i,
  input wire logic [15:0] pressure_adc_i,
  input wire logic [15:0] temperature_adc_i,
  output logic done_o,
  output logic [15:0] result_o,
  output logic adc_start_o,
  output logic adc_temp_o,
  output logic busy_o
);

  if (CONV_MCLK < 1 || CONV_MCLK > 65535)
  begin : g_bad_count
    $error("CONV_MCLK out of range");
  end

  logic [2:0] mclk_s_r;
  logic [2:0] start_s_r;
  logic [2:0] taken_s_r;
  logic [1:0] sel_s_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;

  wire mclk_rise = mclk_s_r[1] & ~mclk_s_r[2];
  wire start_ev = start_s_r[1] ^ start_s_r[2];
  wire taken_ev = taken_s_r[1] ^ taken_s_r[2];
  wire last_tick = busy_o && mclk_rise && (cnt_r == 16'(CONV_MCLK - 1));

  assign cnt_nxt = mclk_rise ? cnt_r + 16'h0001 : cnt_r;

  // Master clock and link toggles cross through two stages first
  always_ff @(posedge core_clk_i)
  begin
    mclk_s_r <= {mclk_s_r[1:0], mclk_i};
    start_s_r <= {start_s_r[1:0], start_tg_i};
    taken_s_r <= {taken_s_r[1:0], taken_tg_i};
    sel_s_r <= {sel_s_r[0], temp_sel_i};
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      busy_o <= 1'b0;
      cnt_r <= 16'h0000;
      adc_start_o <= 1'b0;
      adc_temp_o <= 1'b0;
    end
    else
    begin
      adc_start_o <= start_ev;
      if (start_ev)
      begin
        busy_o <= 1'b1;
        cnt_r <= 16'h0000;
        adc_temp_o <= sel_s_r[1];
      end
      else if (last_tick)
        busy_o <= 1'b0;
      else if (busy_o)
        cnt_r <= cnt_nxt;
    end
  end

  // Result stays frozen until the next conversion, so the link may read it unsynchronised
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      done_o <= 1'b0;
      result_o <= 16'h0000;
    end
    else
    begin
      if (last_tick)
      begin
        done_o <= 1'b1;
        result_o <= adc_temp_o ? temperature_adc_i : pressure_adc_i;
      end
      else if (taken_ev || start_ev)
        done_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** rtl/psr_readout.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psr_defs.svh"

module psr_readout
  import psr_pkg::*;
#(
  parameter int CONV_MCLK = `PSR_CONV_MCLK,
  parameter int RES_W = `PSR_RES_W,
  parameter logic [15:0] CALIB_W1 = `PSR_CALIB_W1,
  parameter logic [15:0] CALIB_W2 = `PSR_CALIB_W2,
  parameter logic [15:0] CALIB_W3 = `PSR_CALIB_W3,
  parameter logic [15:0] CALIB_W4 = `PSR_CALIB_W4
)
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic mclk_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic [15:0] pressure_adc_i,
  input wire logic [15:0] temperature_adc_i,
  output logic dout_o,
  output logic adc_start_o,
  output logic adc_temp_o,
  output logic conv_busy_o
);

  if (RES_W != 16)
  begin : g_bad_width
    $error("RES_W must be 16");
  end

  // Setup field decode; the same match serves frame detection
  function automatic psr_cmd_t cmd_decode(input logic [9:0] bits);
    psr_cmd_t c;
    c = PSR_CMD_NONE;
    if (bits[9:7] == `PSR_START_RUN && bits[2:0] == `PSR_STOP_RUN)
    begin
      case (bits[6:3])
        `PSR_CODE_PRESS: c = PSR_CMD_PRESS;
        `PSR_CODE_TEMP: c = PSR_CMD_TEMP;
        `PSR_CODE_CAL13: c = PSR_CMD_CAL13;
        `PSR_CODE_CAL24: c = PSR_CMD_CAL24;
        default: c = PSR_CMD_NONE;
      endcase
    end
    return c;
  endfunction

  // Link side, clocked only by the host serial clock
  logic [1:0] lrst_s_r;
  logic [`PSR_RST_LEN-1:0] hist_r;
  logic [`PSR_RST_LEN-1:0] hist_nxt;
  psr_state_t state_r;
  psr_state_t state_nxt;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [31:0] sh_r;
  logic [31:0] sh_nxt;
  logic dout_nxt;
  logic start_tg_r;
  logic taken_tg_r;
  logic temp_sel_r;
  logic wait_r;

  wire link_rst = lrst_s_r[1];
  wire conv_done;
  wire [15:0] conv_result;
  wire [`PSR_RST_LEN-1:0] hist_shift = {hist_r[`PSR_RST_LEN-2:0], din_i};
  wire rst_hit = (hist_shift == `PSR_RST_PAT);
  wire psr_cmd_t cmd = cmd_decode(hist_shift[9:0]);
  wire conv_cmd = (cmd == PSR_CMD_PRESS) || (cmd == PSR_CMD_TEMP);
  wire cal_cmd = (cmd == PSR_CMD_CAL13) || (cmd == PSR_CMD_CAL24);
  wire [31:0] cal_words = (cmd == PSR_CMD_CAL13) ? {CALIB_W1, CALIB_W3} : {CALIB_W2, CALIB_W4};
  wire ack_last = (cnt_r == `PSR_ACK_CLKS - 6'h01);
  wire read_last = (cnt_r == `PSR_READ_CLKS - 6'h01);
  wire cal_last = (cnt_r == `PSR_CAL_LEAD + `PSR_CAL_BITS - 6'h01);
  wire cal_lead = (cnt_r < `PSR_CAL_LEAD);
  // Done from the core pulls data out low while the serial clock is parked
  wire dout_clr = conv_done & wait_r;

  // The pattern is cleared after a hit so its tail cannot seed a false frame
  assign hist_nxt = rst_hit ? '0 : hist_shift;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    dout_nxt = dout_o;
    if (rst_hit)
    begin
      state_nxt = PSR_IDLE;
      cnt_nxt = 6'h00;
      dout_nxt = 1'b0;
    end
    else
    begin
      case (state_r)
        PSR_IDLE:
        begin
          dout_nxt = 1'b0;
          cnt_nxt = 6'h00;
          if (conv_cmd)
          begin
            state_nxt = PSR_ACK;
            dout_nxt = 1'b1;
          end
          else if (cal_cmd)
          begin
            state_nxt = PSR_CAL;
            sh_nxt = cal_words;
          end
        end
        PSR_ACK:
        begin
          cnt_nxt = cnt_r + 6'h01;
          if (ack_last)
          begin
            state_nxt = PSR_WAIT;
            cnt_nxt = 6'h00;
          end
        end
        PSR_WAIT:
        begin
          // First clock after done is a dummy bit; done already pulled data out low
          state_nxt = PSR_READ;
          sh_nxt = {conv_result, 16'h0000};
          cnt_nxt = 6'h01;
          dout_nxt = 1'b0;
        end
        PSR_READ:
        begin
          dout_nxt = sh_r[31];
          sh_nxt = {sh_r[30:0], 1'b0};
          cnt_nxt = cnt_r + 6'h01;
          if (read_last)
            state_nxt = PSR_IDLE;
        end
        PSR_CAL:
        begin
          cnt_nxt = cnt_r + 6'h01;
          if (cal_lead)
            dout_nxt = 1'b0;
          else
          begin
            dout_nxt = sh_r[31];
            sh_nxt = {sh_r[30:0], 1'b0};
          end
          if (cal_last)
            state_nxt = PSR_IDLE;
        end
        default:
        begin
          state_nxt = PSR_IDLE;
          cnt_nxt = 6'h00;
          dout_nxt = 1'b0;
        end
      endcase
    end
  end

  // Core reset reaches the link through two stages; it takes effect on serial clock edges only
  always_ff @(posedge sclk_i)
  begin
    lrst_s_r <= {lrst_s_r[0], sys_rst_i};
  end

  // Every link step is paced by host clock edges, so a pause only freezes state
  always_ff @(posedge sclk_i)
  begin
    if (link_rst)
    begin
      hist_r <= '0;
      state_r <= PSR_IDLE;
      cnt_r <= 6'h00;
      sh_r <= 32'h0000_0000;
      wait_r <= 1'b0;
    end
    else
    begin
      hist_r <= hist_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      wait_r <= (state_nxt == PSR_WAIT);
    end
  end

  // Handshake toggles toward the core; the type bit changes on the same serial clock edge as its toggle
  always_ff @(posedge sclk_i)
  begin
    if (link_rst)
    begin
      start_tg_r <= 1'b0;
      taken_tg_r <= 1'b0;
      temp_sel_r <= 1'b0;
    end
    else
    begin
      if (state_r == PSR_IDLE && !rst_hit && conv_cmd)
      begin
        start_tg_r <= ~start_tg_r;
        temp_sel_r <= (cmd == PSR_CMD_TEMP);
      end
      if (state_r == PSR_WAIT && !rst_hit)
        taken_tg_r <= ~taken_tg_r;
    end
  end

  // Only this flop drives data out; clear is built from two flops, never from a pin
  always_ff @(posedge sclk_i or posedge dout_clr)
  begin
    if (dout_clr)
      dout_o <= 1'b0;
    else if (link_rst)
      dout_o <= 1'b0;
    else
      dout_o <= dout_nxt;
  end

  psr_conv #(
    .CONV_MCLK(CONV_MCLK)
  ) u_conv (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .mclk_i(mclk_i),
    .start_tg_i(start_tg_r),
    .temp_sel_i(temp_sel_r),
    .taken_tg_i(taken_tg_r),
    .pressure_adc_i(pressure_adc_i),
    .temperature_adc_i(temperature_adc_i),
    .done_o(conv_done),
    .result_o(conv_result),
    .adc_start_o(adc_start_o),
    .adc_temp_o(adc_temp_o),
    .busy_o(conv_busy_o)
  );

endmodule

`default_nettype wire

// *** test/psr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psr_defs.svh"
module psr_host
(
  input wire logic dout_i,
  output logic sclk_o,
  output logic din_o,
  output logic mclk_o
);
  logic [32:0] q_r;
  initial
  begin
    sclk_o = 1'b0;
    din_o = 1'b0;
    mclk_o = 1'b0;
    forever #15259 mclk_o = ~mclk_o;
  end
  // Idle clock stays low, so pauses are free
  task automatic pulse(input logic b);
    din_o = b;
    #3 sclk_o = 1'b1;
    #3 q_r = {q_r[31:0], dout_i};
    sclk_o = 1'b0;
  endtask
  task automatic clocks(input int n);
    repeat (n) pulse(1'b0);
  endtask
  task automatic frame(input logic [3:0] code);
    logic [9:0] f;
    f = {`PSR_START_RUN, code, `PSR_STOP_RUN};
    for (int i = 9; i >= 0; i--)
      pulse(f[i]);
    din_o = 1'b0;
  endtask
  task automatic rst_seq();
    logic [20:0] p;
    p = `PSR_RST_PAT;
    for (int i = 20; i >= 0; i--)
      pulse(p[i]);
    din_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** test/psr_readout_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psr_defs.svh"
module psr_readout_sva
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic dout_o,
  input wire logic adc_start_o,
  input wire logic adc_temp_o,
  input wire logic conv_busy_o
);
  logic [19:0] hist_r;
  wire logic [20:0] win = {hist_r, din_i};
  wire logic is_conv = win[9:0] == {3'b111, `PSR_CODE_PRESS, 3'b000} || win[9:0] == {3'b111, `PSR_CODE_TEMP, 3'b000};
  wire logic is_cal = win[9:0] == {3'b111, `PSR_CODE_CAL13, 3'b000} || win[9:0] == {3'b111, `PSR_CODE_CAL24, 3'b000};
  always_ff @(posedge sclk_i)
    hist_r <= win[19:0];
  a_ack_rise: assert property (@(posedge sclk_i) disable iff (sys_rst_i) is_conv |=> dout_o [*2])
    else $error("ack missing");
  a_cal_quiet: assert property (@(posedge sclk_i) disable iff (sys_rst_i) is_cal |=> !dout_o [*2])
    else $error("cal read not quiet");
  a_resync_idle: assert property (@(posedge sclk_i) disable iff (sys_rst_i) win == `PSR_RST_PAT |=> !dout_o [*2])
    else $error("reset pattern ignored");
  a_start_pulse: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) adc_start_o |=> !adc_start_o)
    else $error("start pulse too long");
  a_start_busy: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) adc_start_o |-> ##[0:4] conv_busy_o)
    else $error("no busy after start");
  a_busy_dout: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) conv_busy_o |-> dout_o)
    else $error("out low while busy");
  a_temp_stable: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    conv_busy_o && $past(conv_busy_o) |-> $stable(adc_temp_o))
    else $error("select moved");
  a_done_clear: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) $fell(conv_busy_o) |-> ##[0:8] !dout_o)
    else $error("done not shown");
endmodule
bind psr_readout psr_readout_sva chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk_i),
  .din_i(din_i), .dout_o(dout_o), .adc_start_o(adc_start_o), .adc_temp_o(adc_temp_o), .conv_busy_o(conv_busy_o));
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psr_defs.svh"
module testbench;
  logic core_clk_i, sys_rst_i, mclk_i, sclk_i, din_i, dout_o, adc_start_o, adc_temp_o, conv_busy_o;
  logic [15:0] padc, tadc;
  int n_fail, n_tests;
  psr_readout #(.CONV_MCLK(4)) uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .mclk_i(mclk_i),
    .sclk_i(sclk_i), .din_i(din_i), .pressure_adc_i(padc), .temperature_adc_i(tadc), .dout_o(dout_o),
    .adc_start_o(adc_start_o), .adc_temp_o(adc_temp_o), .conv_busy_o(conv_busy_o));
  psr_host host (.dout_i(dout_o), .sclk_o(sclk_i), .din_o(din_i), .mclk_o(mclk_i));
  function automatic logic [32:0] exp_cal(input logic s);
    return s ? {1'b0, `PSR_CALIB_W2, `PSR_CALIB_W4} : {1'b0, `PSR_CALIB_W1, `PSR_CALIB_W3};
  endfunction
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Link reset needs serial clock edges, so the host keeps clocking while reset is held
  task automatic do_reset();
    sys_rst_i <= 1'b1;
    fork
      repeat (5) @(posedge core_clk_i);
      host.clocks(8);
    join
    sys_rst_i <= 1'b0;
    host.clocks(3);
    chk("reset dout", 33'h0, {32'h0, dout_o});
    chk("reset busy", 33'h0, {32'h0, conv_busy_o});
    chk("reset temp", 33'h0, {32'h0, adc_temp_o});
  endtask
  task automatic conv(input logic t, input int gap);
    logic [15:0] v;
    int k;
    v = 16'($urandom);
    @(posedge core_clk_i);
    padc <= v;
    tadc <= ~v;
    host.frame(t ? `PSR_CODE_TEMP : `PSR_CODE_PRESS);
    chk("ack", 33'h1, {32'h0, host.q_r[0]});
    host.clocks(2);
    repeat (8) @(posedge core_clk_i);
    chk("busy", 33'h1, {32'h0, conv_busy_o});
    k = 0;
    while (dout_o !== 1'b0 && k < 20000)
    begin
      @(posedge core_clk_i);
      k++;
    end
    chk("done", 33'h0, {32'h0, dout_o});
    chk("busy end", 33'h0, {32'h0, conv_busy_o});
    chk("temp sel", {32'h0, t}, {32'h0, adc_temp_o});
    host.clocks(9);
    #gap;
    host.clocks(8);
    chk("result", {17'h0, t ? ~v : v}, {16'h0, host.q_r[16:0]});
  endtask
  task automatic cal(input logic s, input logic brk);
    host.frame(s ? `PSR_CODE_CAL24 : `PSR_CODE_CAL13);
    chk("cal ack", 33'h0, {32'h0, host.q_r[0]});
    if (brk)
    begin
      host.clocks(10);
      host.rst_seq();
      host.frame(s ? `PSR_CODE_CAL24 : `PSR_CODE_CAL13);
    end
    host.clocks(33);
    chk("calib", exp_cal(s), host.q_r);
  endtask
  initial
  begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  initial
  begin
    #1500000;
    n_fail++;
    complete_run();
  end
  initial
  begin
    n_fail = 0;
    n_tests = 0;
    sys_rst_i = 1'b1;
    padc = 16'h0000;
    tadc = 16'h0000;
    void'($urandom(92));
    do_reset();
    host.rst_seq();
    cal(1'b0, 1'b0);
    cal(1'b1, 1'b0);
    for (int i = 0; i < 4; i++)
      conv(i[0], $urandom_range(0, 300));
    host.frame(4'h3);
    host.clocks(4);
    chk("bad code", 33'h0, {29'h0, host.q_r[3:0]});
    // Reset in mid conversion must drop busy, the type bit and the acknowledge
    host.frame(`PSR_CODE_TEMP);
    host.clocks(2);
    repeat (8) @(posedge core_clk_i);
    chk("busy pre-reset", 33'h1, {32'h0, conv_busy_o});
    chk("temp pre-reset", 33'h1, {32'h0, adc_temp_o});
    do_reset();
    host.rst_seq();
    cal(1'b1, 1'b1);
    conv(1'b0, 0);
    complete_run();
  end
endmodule
`default_nettype wire
